// *** hw/uart_pkg.sv ***
// Constants shared by the serial port and its testbench
package uart_pkg;
    // Register addresses on the special-function-register bus
    localparam logic [7:0] ADDR_XBAR_ROUTE = 8'hE2;
    localparam logic [7:0] ADDR_SER_CTRL = 8'hA0;
    localparam logic [7:0] ADDR_SER_DATA = 8'hA1;
    localparam logic [7:0] ADDR_TMR_LOW = 8'hA2;
    localparam logic [7:0] ADDR_TMR_RELOAD = 8'hA3;
    localparam logic [7:0] ADDR_TMR_CLKCFG = 8'hA4;
    localparam logic [7:0] ADDR_TMR_RUN = 8'hA5;
    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    // Serial control field positions
    localparam int CTL_MODE9 = 7;
    localparam int CTL_IRQ_EN = 6;
    localparam int CTL_RX_EN = 4;
    localparam int CTL_TX_NINTH = 3;
    localparam int CTL_RX_NINTH = 2;
    localparam int CTL_TX_DONE = 1;
    localparam int CTL_RX_DONE = 0;
    // Crossbar route field positions
    localparam int XB_RX_ROUTE = 1;
    localparam int XB_TX_ROUTE = 0;
    // Timer clock config field positions
    localparam int CFG_CLK_SEL = 3;
    localparam int CFG_EXT_CNT = 2;
    localparam int CFG_RUN = 0;
    // Prescale select codes
    localparam logic [1:0] PRE_DIV12 = 2'h0;
    localparam logic [1:0] PRE_DIV4 = 2'h1;
    localparam logic [1:0] PRE_DIV48 = 2'h2;
    localparam logic [1:0] PRE_EXT8 = 2'h3;
    // Terminal counts of the prescaler (divisor minus one)
    localparam logic [5:0] PRE_MAX12 = 6'h0B;
    localparam logic [5:0] PRE_MAX4 = 6'h03;
    localparam logic [5:0] PRE_MAX48 = 6'h2F;
    localparam logic [2:0] EXT_OSC_MAX = 3'h7;
    // Timer terminal count
    localparam logic [7:0] TMR_TOP = 8'hFF;
    // Transmit frame lengths in baud ticks (bits plus one closing tick) and last receive data bit index
    localparam logic [3:0] TX_TICKS8 = 4'hB;
    localparam logic [3:0] TX_TICKS9 = 4'hC;
    localparam logic [3:0] RX_LAST8 = 4'h7;
    localparam logic [3:0] RX_LAST9 = 4'h8;
    // Receive word width: eight data bits and the ninth bit
    localparam int RX_WORD_W = 9;
    localparam int RX_BUF_DEPTH = 2;
endpackage

// *** hw/uart_rx_buffer.sv ***
// Small valid/ready buffer for received words
`timescale 1ns/1ps
`default_nettype none
module uart_rx_buffer
#(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST_C = (AW)'(DEPTH - 1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;

    // Honest full and empty from the fill count
    assign in_ready = (cnt_ff != DEPTH_C);
    assign out_valid = (cnt_ff != '0);
    assign out_data = mem_ff[rd_ptr_ff];

    // Storage written at the write pointer
    always_ff @(posedge CLK)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data;
    end

    // Pointers and fill count
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? '0 : wr_ptr_ff + 1'b1;
            if (pop)
                rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? '0 : rd_ptr_ff + 1'b1;
            if (push && !pop)
                cnt_ff <= cnt_ff + 1'b1;
            else if (pop && !push)
                cnt_ff <= cnt_ff - 1'b1;
        end
    end
endmodule // uart_rx_buffer
`default_nettype wire

// *** hw/uart_timer_port.sv ***
// Serial port with timer-based baud generation and pin routing
//
// Contract
// RULE1 - Full duplex, 8-bit and 9-bit modes only
// RULE2 - Buffered receiver accepts next byte meanwhile
// RULE3 - Data address: write transmits, read receives
// RULE4 - Interrupt on transmit-done or receive-done
// RULE5 - Done flags stay set until software clears
// RULE6 - Transmit clock from auto-reload timer overflows
// RULE7 - Hidden receive counter copy, same reload
// RULE8 - Both overflows divided by two
// RULE9 - Start bit forces receive counter reload
// RULE10 - Six selectable timer clock sources
// RULE11 - Overflow rate clock over 256 minus reload
// RULE12 - Clock select bit and prescale codes
// RULE13 - External oscillator clocks timer, not system
// RULE14 - Route bits connect transmit and receive pins
// RULE15 - Start, data LSB first, ninth, stop
`timescale 1ns/1ps
`default_nettype none
module uart_timer_port
import uart_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic EXT_OSC,
    input wire logic EXT_TIMER_IN,
    input wire logic RX_PIN,
    output logic TX_PIN_OUT,
    output logic TX_PIN_OE,
    output logic UART_IRQ
);
    typedef enum logic [1:0] {TX_IDLE, TX_SEND} tx_state_t;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP, RX_PUSH} rx_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] xbar_ff;
    logic [7:0] ctl_ff;
    logic [7:0] low_ff;
    logic [7:0] rx_low_ff;
    logic [7:0] reload_ff;
    logic [3:0] clkcfg_ff;
    logic run_ff;
    logic [7:0] rx_hold_ff;
    logic [7:0] rdata_ff;
    logic irq_ff;
    logic tx_line_ff;
    logic [5:0] presc_ff;
    logic [2:0] osc_cnt_ff;
    logic osc_q_ff;
    logic tpin_q_ff;
    logic rx_q_ff;
    logic tx_half_ff;
    logic rx_half_ff;
    tx_state_t tx_state_ff;
    rx_state_t rx_state_ff;
    logic [10:0] tx_bits_ff;
    logic [3:0] tx_left_ff;
    logic [3:0] rx_cnt_ff;
    logic [8:0] rx_word_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode
    wire wr_xbar = SFR_WR && (SFR_ADDR == ADDR_XBAR_ROUTE);
    wire wr_ctl = SFR_WR && (SFR_ADDR == ADDR_SER_CTRL);
    wire wr_data = SFR_WR && (SFR_ADDR == ADDR_SER_DATA);
    wire wr_low = SFR_WR && (SFR_ADDR == ADDR_TMR_LOW);
    wire wr_reload = SFR_WR && (SFR_ADDR == ADDR_TMR_RELOAD);
    wire wr_cfg = SFR_WR && (SFR_ADDR == ADDR_TMR_CLKCFG);
    wire wr_run = SFR_WR && (SFR_ADDR == ADDR_TMR_RUN);
    wire mode9 = ctl_ff[CTL_MODE9]; // RULE1

    // Read mux; data address returns only the receive holding register
    wire [7:0] rd_mux =
        (SFR_ADDR == ADDR_XBAR_ROUTE) ? xbar_ff :
        (SFR_ADDR == ADDR_SER_CTRL) ? ctl_ff :
        (SFR_ADDR == ADDR_SER_DATA) ? rx_hold_ff : // RULE3
        (SFR_ADDR == ADDR_TMR_LOW) ? low_ff :
        (SFR_ADDR == ADDR_TMR_RELOAD) ? reload_ff :
        (SFR_ADDR == ADDR_TMR_CLKCFG) ? {4'h0, clkcfg_ff} :
        (SFR_ADDR == ADDR_TMR_RUN) ? {7'h00, run_ff} : RST_BYTE;

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock source selection
    wire [1:0] pre_sel = clkcfg_ff[1:0];
    wire [5:0] presc_max =
        (pre_sel == PRE_DIV4) ? PRE_MAX4 :
        (pre_sel == PRE_DIV48) ? PRE_MAX48 : PRE_MAX12; // RULE12
    wire presc_tick = (presc_ff == presc_max);
    wire osc_edge = EXT_OSC && !osc_q_ff;
    wire osc_tick = osc_edge && (osc_cnt_ff == EXT_OSC_MAX); // RULE13
    wire tpin_edge = EXT_TIMER_IN && !tpin_q_ff;
    wire pre_tick = (pre_sel == PRE_EXT8) ? osc_tick : presc_tick;
    wire src_tick =
        clkcfg_ff[CFG_EXT_CNT] ? tpin_edge :
        clkcfg_ff[CFG_CLK_SEL] ? 1'b1 : pre_tick; // RULE10 RULE12
    wire tmr_tick = run_ff && src_tick;

    ////////////////////////////////////////////////////////////////////////////
    // Overflows and divide-by-two baud ticks
    wire tx_ovf = tmr_tick && (low_ff == TMR_TOP); // RULE6
    wire rx_ovf = tmr_tick && (rx_low_ff == TMR_TOP); // RULE7
    wire tx_tick = tx_ovf && tx_half_ff; // RULE8
    wire rx_tick = rx_ovf && !rx_half_ff; // RULE8
    wire rx_in = xbar_ff[XB_RX_ROUTE] ? RX_PIN : 1'b1; // RULE14
    wire start_det = (rx_state_ff == RX_IDLE) && ctl_ff[CTL_RX_EN]
                     && rx_q_ff && !rx_in; // RULE9

    ////////////////////////////////////////////////////////////////////////////
    // Receive buffer and drain into the holding register
    wire buf_in_ready;
    wire buf_out_valid;
    wire [8:0] buf_out_data;
    wire buf_push = (rx_state_ff == RX_PUSH);
    wire rx_pop = buf_out_valid && !ctl_ff[CTL_RX_DONE]; // RULE2
    wire tx_end = (tx_state_ff == TX_SEND) && tx_tick && (tx_left_ff == 4'h1);

    uart_rx_buffer #(
        .WIDTH(RX_WORD_W),
        .DEPTH(RX_BUF_DEPTH)
    ) u_rx_buffer (
        .CLK(CLK),
        .RST_B(RST_B),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data(rx_word_ff),
        .out_valid(buf_out_valid),
        .out_ready(!ctl_ff[CTL_RX_DONE]),
        .out_data(buf_out_data)
    );

    // Control flags: hardware set wins over a software clear
    wire [7:0] ctl_wr = wr_ctl ? SFR_WDATA : ctl_ff;
    wire nxt_tx_done = tx_end || ctl_wr[CTL_TX_DONE]; // RULE4 RULE5
    wire nxt_rx_done = rx_pop || ctl_wr[CTL_RX_DONE]; // RULE4 RULE5
    wire nxt_rx_ninth = rx_pop ? buf_out_data[8] : ctl_wr[CTL_RX_NINTH];
    wire [7:0] nxt_ctl = {ctl_wr[7:6], 1'b0, ctl_wr[4:3], nxt_rx_ninth, nxt_tx_done, nxt_rx_done};

    ////////////////////////////////////////////////////////////////////////////
    // Software-visible registers and output flops
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            xbar_ff <= RST_BYTE;
            ctl_ff <= RST_BYTE;
            reload_ff <= RST_BYTE;
            clkcfg_ff <= 4'h0;
            run_ff <= 1'b0;
            rx_hold_ff <= RST_BYTE;
            rdata_ff <= RST_BYTE;
            irq_ff <= 1'b0;
        end
        else
        begin
            if (wr_xbar)
                xbar_ff <= SFR_WDATA;
            ctl_ff <= nxt_ctl;
            if (wr_reload)
                reload_ff <= SFR_WDATA;
            if (wr_cfg)
                clkcfg_ff <= SFR_WDATA[3:0];
            if (wr_run)
                run_ff <= SFR_WDATA[CFG_RUN];
            if (rx_pop)
                rx_hold_ff <= buf_out_data[7:0]; // RULE2
            if (SFR_RD)
                rdata_ff <= rd_mux; // RULE3
            irq_ff <= nxt_ctl[CTL_IRQ_EN] && (nxt_tx_done || nxt_rx_done); // RULE4
        end
    end

    // Prescaler and input edge samplers
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            presc_ff <= 6'h00;
            osc_cnt_ff <= 3'h0;
            osc_q_ff <= 1'b0;
            tpin_q_ff <= 1'b0;
            rx_q_ff <= 1'b1;
        end
        else
        begin
            presc_ff <= presc_tick ? 6'h00 : presc_ff + 6'h01; // RULE10
            if (osc_edge)
                osc_cnt_ff <= osc_cnt_ff + 3'h1; // RULE13
            osc_q_ff <= EXT_OSC;
            tpin_q_ff <= EXT_TIMER_IN;
            rx_q_ff <= rx_in;
        end
    end

    // Transmit counter and its hidden receive copy, both auto-reloading
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            low_ff <= RST_BYTE;
            rx_low_ff <= RST_BYTE;
            tx_half_ff <= 1'b0;
            rx_half_ff <= 1'b0;
        end
        else
        begin
            if (wr_low)
                low_ff <= SFR_WDATA;
            else if (tmr_tick)
                low_ff <= tx_ovf ? reload_ff : low_ff + 8'h01; // RULE6 RULE11
            if (start_det)
                rx_low_ff <= reload_ff; // RULE9
            else if (tmr_tick)
                rx_low_ff <= rx_ovf ? reload_ff : rx_low_ff + 8'h01; // RULE7
            if (tx_ovf)
                tx_half_ff <= !tx_half_ff; // RULE8
            if (start_det)
                rx_half_ff <= 1'b0; // RULE9
            else if (rx_ovf)
                rx_half_ff <= !rx_half_ff; // RULE8
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter: start, data LSB first, optional ninth bit, stop
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            tx_state_ff <= TX_IDLE;
            tx_bits_ff <= 11'h7FF;
            tx_left_ff <= 4'h0;
            tx_line_ff <= 1'b1;
        end
        else
        begin
            case (tx_state_ff)
                TX_IDLE:
                begin
                    tx_line_ff <= 1'b1;
                    if (wr_data)
                    begin
                        tx_bits_ff <= {1'b1, mode9 ? ctl_ff[CTL_TX_NINTH] : 1'b1, SFR_WDATA, 1'b0}; // RULE15
                        tx_left_ff <= mode9 ? TX_TICKS9 : TX_TICKS8; // RULE1
                        tx_state_ff <= TX_SEND;
                    end
                end
                TX_SEND:
                begin
                    if (tx_tick)
                    begin
                        tx_left_ff <= tx_left_ff - 4'h1;
                        tx_line_ff <= tx_bits_ff[0]; // RULE15
                        tx_bits_ff <= {1'b1, tx_bits_ff[10:1]};
                        if (tx_left_ff == 4'h1)
                        begin
                            tx_line_ff <= 1'b1;
                            tx_state_ff <= TX_IDLE;
                        end
                    end
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver: samples each bit at mid-point after the forced reload
    always_ff @(posedge CLK)
    begin
        if (!RST_B)
        begin
            rx_state_ff <= RX_IDLE;
            rx_cnt_ff <= 4'h0;
            rx_word_ff <= 9'h000;
        end
        else
        begin
            case (rx_state_ff)
                RX_IDLE:
                    if (start_det)
                        rx_state_ff <= RX_START; // RULE9
                RX_START:
                    if (rx_tick)
                    begin
                        rx_cnt_ff <= 4'h0;
                        rx_state_ff <= rx_in ? RX_IDLE : RX_DATA;
                    end
                RX_DATA:
                    if (rx_tick)
                    begin
                        rx_word_ff[rx_cnt_ff] <= rx_in; // RULE15
                        rx_cnt_ff <= rx_cnt_ff + 4'h1;
                        if (rx_cnt_ff == (mode9 ? RX_LAST9 : RX_LAST8))
                            rx_state_ff <= RX_STOP; // RULE1
                    end
                RX_STOP:
                    if (rx_tick)
                    begin
                        if (!mode9)
                            rx_word_ff[8] <= rx_in;
                        rx_state_ff <= RX_PUSH;
                    end
                RX_PUSH:
                    if (buf_in_ready)
                        rx_state_ff <= RX_IDLE; // RULE2
                default: rx_state_ff <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign SFR_RDATA = rdata_ff;
    assign TX_PIN_OUT = tx_line_ff;
    assign TX_PIN_OE = xbar_ff[XB_TX_ROUTE]; // RULE14
    assign UART_IRQ = irq_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    a_tx_idle_high: assert property (@(posedge CLK) disable iff (!RST_B) // RULE15
        (tx_state_ff == TX_IDLE) |=> TX_PIN_OUT)
        else $error("transmit line low while idle");
    a_tx_done_set: assert property (@(posedge CLK) disable iff (!RST_B) // RULE4
        tx_end |=> ctl_ff[CTL_TX_DONE] && (tx_state_ff == TX_IDLE))
        else $error("transmit done flag not set at frame end");
    a_flag_sticky: assert property (@(posedge CLK) disable iff (!RST_B) // RULE5
        ctl_ff[CTL_RX_DONE] && !wr_ctl |=> ctl_ff[CTL_RX_DONE])
        else $error("receive done flag dropped without software");
    a_irq_follow: assert property (@(posedge CLK) disable iff (!RST_B) // RULE4
        ctl_ff[CTL_IRQ_EN] && (ctl_ff[CTL_TX_DONE] || ctl_ff[CTL_RX_DONE]) |-> UART_IRQ)
        else $error("interrupt missing while flag set");
    a_rx_reload: assert property (@(posedge CLK) disable iff (!RST_B) // RULE9
        start_det |=> (rx_low_ff == $past(reload_ff)) && !rx_half_ff)
        else $error("receive counter not reloaded on start");
    a_tx_reload: assert property (@(posedge CLK) disable iff (!RST_B) // RULE6
        tx_ovf && !wr_low |=> low_ff == $past(reload_ff))
        else $error("transmit counter not reloaded on overflow");
    a_half_rate: assert property (@(posedge CLK) disable iff (!RST_B) // RULE8
        tx_tick |-> ##1 !tx_half_ff)
        else $error("transmit tick not every second overflow");
    a_route_oe: assert property (@(posedge CLK) disable iff (!RST_B) // RULE14
        wr_xbar |=> TX_PIN_OE == $past(SFR_WDATA[XB_TX_ROUTE]))
        else $error("transmit route enable not applied");
    a_presc_div4: assert property (@(posedge CLK) disable iff (!RST_B) // RULE12
        presc_tick && (pre_sel == PRE_DIV4) && !wr_cfg |=> !presc_tick [*3]
        ##1 (presc_ff == PRE_MAX4) && (presc_tick || (pre_sel != PRE_DIV4)))
        else $error("divide by four prescale wrong");
    a_rd_data: assert property (@(posedge CLK) disable iff (!RST_B) // RULE3
        SFR_RD && (SFR_ADDR == ADDR_SER_DATA) |=> SFR_RDATA == $past(rx_hold_ff))
        else $error("data read did not return receive register");
endmodule // uart_timer_port
`default_nettype wire

// *** tb/uart_remote_node.sv ***
// Remote serial node facing the port across its transmit and receive pins
`timescale 1ns/1ps
`default_nettype none
module uart_remote_node
(
    input wire logic clk,
    input wire logic tx_line,
    input wire logic tx_oe,
    output logic rx_line
);
    int bit_cyc = 8;
    logic nine = 1'b0;
    logic [8:0] got_q [$];
    int frame_err = 0;
    wire logic line_lv;

    ////////////////////////////////////////////////////////////////////////
    // Transmit pin not driven by the port reads as the pulled-up idle level
    assign line_lv = tx_oe ? tx_line : 1'b1;
    initial rx_line = 1'b1;

    // Send one frame: start, data LSB first, optional ninth, stop
    task automatic send(input logic [8:0] w);
        int i;
        @(posedge clk);
        rx_line <= 1'b0;
        repeat (bit_cyc) @(posedge clk);
        for (i = 0; i < (nine ? 9 : 8); i++)
        begin
            rx_line <= w[i];
            repeat (bit_cyc) @(posedge clk);
        end
        rx_line <= 1'b1;
        repeat (bit_cyc) @(posedge clk);
    endtask

    // Receive frames at mid-bit and queue them, counting bad framing
    initial
    begin : rx_side
        logic [8:0] w;
        int i;
        logic ok;
        forever
        begin
            @(negedge line_lv);
            repeat (bit_cyc / 2) @(posedge clk);
            w = 9'h000;
            ok = (line_lv === 1'b0);
            for (i = 0; i < (nine ? 9 : 8); i++)
            begin
                repeat (bit_cyc) @(posedge clk);
                w[i] = line_lv;
            end
            repeat (bit_cyc) @(posedge clk);
            if (!ok || line_lv !== 1'b1)
                frame_err++;
            got_q.push_back(w);
        end
    end
endmodule // uart_remote_node
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the timer-clocked serial port
`timescale 1ns/1ps
`default_nettype none
module tb_top
import uart_pkg::*;
;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic ext_osc = 1'b0;
    logic ext_tin = 1'b0;
    wire logic [7:0] rdata;
    wire logic tx_out;
    wire logic tx_oe;
    wire logic irq;
    wire logic rx_line;
    int fails = 0;
    int checked = 0;
    logic [7:0] regs [7] = '{8'hA0, 8'hA1, 8'hA2, 8'hA3, 8'hA4, 8'hA5, 8'hE2};
    logic [7:0] cfgs [6] = '{8'h08, 8'h01, 8'h00, 8'h02, 8'h03, 8'h04};
    int cyc [6] = '{8, 32, 96, 384, 128, 16};

    ////////////////////////////////////////////////////////////////////////
    // Clock and free-running external clock sources
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        ext_osc <= ~ext_osc;
        ext_tin <= ~ext_tin;
    end

    uart_timer_port dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WDATA(wdata),
        .SFR_WR(wr), .SFR_RD(rd), .SFR_RDATA(rdata), .EXT_OSC(ext_osc), .EXT_TIMER_IN(ext_tin),
        .RX_PIN(rx_line), .TX_PIN_OUT(tx_out), .TX_PIN_OE(tx_oe), .UART_IRQ(irq));
    uart_remote_node far (.clk(clk), .tx_line(tx_out), .tx_oe(tx_oe), .rx_line(rx_line));

    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Register bus cycles: one-cycle strobes, read data one cycle later
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        #1 d = rdata;
    endtask

    // Poll a control flag with a bounded count
    task automatic wait_flag(input int b);
        logic [7:0] v;
        int n;
        v = 8'h00;
        n = 0;
        while (v[b] !== 1'b1)
        begin
            if (n == 3000)
            begin
                fails++;
                finish_test();
            end
            rd_reg(ADDR_SER_CTRL, v);
            n++;
        end
    endtask

    // Send one word and check what the far side saw
    task automatic tx_byte(input logic [7:0] d, input logic [8:0] w, input logic [7:0] ctl);
        logic [7:0] v;
        wr_reg(ADDR_SER_DATA, d);
        wait_flag(CTL_TX_DONE);
        chk(irq, 1'b1);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v[CTL_TX_DONE], 1'b1);
        chk(9'(far.got_q.size()), 9'h001);
        chk(far.got_q.pop_front(), w);
        wr_reg(ADDR_SER_CTRL, ctl);
    endtask

    // Collect one received word and clear its flag
    task automatic rx_word(input logic [8:0] w, input logic [7:0] ctl);
        logic [7:0] v;
        wait_flag(CTL_RX_DONE);
        chk(irq, 1'b1);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v, ctl | 8'h01 | {5'h00, w[8], 2'h0});
        rd_reg(ADDR_SER_DATA, v);
        chk(v, w[7:0]);
        wr_reg(ADDR_SER_CTRL, ctl);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] v;
        int k;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        for (k = 0; k < 7; k++)
        begin
            rd_reg(regs[k], v);
            chk(v, 8'h00);
        end
        // Timer low count takes a write while the timer is stopped
        wr_reg(ADDR_TMR_LOW, 8'hFC);
        rd_reg(ADDR_TMR_LOW, v);
        chk(v, 8'hFC);
        chk(tx_out, 1'b1);
        chk(tx_oe, 1'b0);
        chk(irq, 1'b0);
        // Unmapped place, route bits, control flags and interrupt
        wr_reg(8'h10, 8'hFF);
        rd_reg(8'h10, v);
        chk(v, 8'h00);
        wr_reg(ADDR_XBAR_ROUTE, 8'h03);
        rd_reg(ADDR_XBAR_ROUTE, v);
        chk(v, 8'h03);
        chk(tx_oe, 1'b1);
        wr_reg(ADDR_SER_CTRL, 8'h7F);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v, 8'h5F);
        chk(irq, 1'b1);
        wr_reg(ADDR_SER_CTRL, 8'h50);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v, 8'h50);
        chk(irq, 1'b0);
        // Every timer clock source, bit period from reload 0xFC
        wr_reg(ADDR_TMR_RELOAD, 8'hFC);
        wr_reg(ADDR_TMR_RUN, 8'h01);
        for (k = 0; k < 6; k++)
        begin
            far.bit_cyc = cyc[k];
            wr_reg(ADDR_TMR_CLKCFG, cfgs[k]);
            tx_byte(8'h31 + k[7:0], {1'b0, 8'h31 + k[7:0]}, 8'h50);
        end
        // Three back-to-back frames at an odd phase before any read
        far.bit_cyc = 16;
        wr_reg(ADDR_TMR_RELOAD, 8'hF8);
        wr_reg(ADDR_TMR_CLKCFG, 8'h08);
        repeat (7) @(posedge clk);
        far.send(9'h13C);
        far.send(9'h1C3);
        far.send(9'h10F);
        rx_word(9'h13C, 8'h50);
        rx_word(9'h1C3, 8'h50);
        rx_word(9'h10F, 8'h50);
        // Receive route off, then receiver off: neither frame may land
        wr_reg(ADDR_XBAR_ROUTE, 8'h01);
        far.send(9'h1AA);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v, 8'h50);
        wr_reg(ADDR_XBAR_ROUTE, 8'h03);
        wr_reg(ADDR_SER_CTRL, 8'h40);
        far.send(9'h155);
        rd_reg(ADDR_SER_CTRL, v);
        chk(v, 8'h40);
        rd_reg(ADDR_SER_DATA, v);
        chk(v, 8'h0F);
        // Nine-bit mode both ways
        far.nine = 1'b1;
        wr_reg(ADDR_SER_CTRL, 8'hD8);
        tx_byte(8'h5A, 9'h15A, 8'hD8);
        far.send(9'h0A5);
        rx_word(9'h0A5, 8'hD8);
        far.send(9'h1C3);
        rx_word(9'h1C3, 8'hD8);
        chk(9'(far.frame_err), 9'h000);
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
